// ### hdl/pwr_ctl.sv
// idle/sleep entry and wake control with peripheral bus clock divider
// Summary of operation
// - in sleep, a running enabled interrupt above cpu priority wakes the cpu
// - sleep wake at or below priority: cpu stays halted, bus clock restarts, enter idle
// - any reset or watchdog time-out ends both sleep and idle
// - idle halts the cpu while the system clock keeps running
// - each peripheral's stop_in_idle bit halts it in idle, else it runs
// - wait enters idle when sleep_on_wait_select clear, sleep when set
// - in idle, only an interrupt above cpu priority, a reset or a watchdog time-out wakes the cpu
// - divisor field bits 20:19 selects ratios 1:1, 1:2, 1:4, 1:8
// - system-clock units get an enable unaffected by the divisor, low only in sleep
// - peripheral reads complete on the next peripheral clock edge
// - switching to a stopped crystal or pll source inserts startup/lock delay
`timescale 1ns/10ps
`default_nettype none
module pwr_ctl
  import pwr_ctl_pkg::*;
#(
  parameter int OSC_START_CYCLES = OSC_START_CYC,
  parameter int PLL_LOCK_CYCLES  = PLL_LOCK_CYC
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [OSC_CTL_W-1:0] oscillator_control_reg_i,
  input  wire logic                 wait_exec_i,
  input  wire logic                 wdt_timeout_i,
  input  wire logic                 dev_reset_i,
  input  wire logic                 irq_valid_i,
  input  wire logic                 irq_runs_in_sleep_i,
  input  wire logic [PRIO_W-1:0]    irq_prio_i,
  input  wire logic [PRIO_W-1:0]    cpu_prio_i,
  input  wire logic [PERIPH_N-1:0]  stop_in_idle_i,
  input  wire logic                 clk_switch_i,
  input  wire logic                 new_src_stopped_i,
  input  wire logic                 new_src_xtal_i,
  input  wire logic                 new_src_pll_i,
  input  wire logic                 periph_rd_req_i,
  output logic                      cpu_run_o,
  output logic                      sys_clk_en_o,
  output logic                      system_core_clock_unit_en_o,
  output logic                      periph_bus_clock_o,
  output logic [PERIPH_N-1:0]       periph_clk_en_o,
  output logic                      periph_rd_done_o,
  output logic                      src_ready_o,
  output logic [1:0]                pwr_mode_o,
  output logic [DIV_W-1:0]          active_div_o
);
  pwr_state_t          state;
  pwr_state_t          next_state;
  logic [DELAY_W-1:0]  delay_cnt;
  logic                rd_pending;
  wire                 sleep_sel;
  wire [DIV_W-1:0]     div_sel;
  wire                 wake_any;
  wire                 wake_cpu;
  wire                 abort_lp;
  wire                 bus_run;
  wire                 tick;
  wire                 need_delay;
  wire [DELAY_W-1:0]   delay_load;

  assign sleep_sel  = oscillator_control_reg_i[SLEEP_SEL_BIT];
  assign div_sel    = oscillator_control_reg_i[DIV_MSB_BIT:DIV_LSB_BIT];
  assign abort_lp   = dev_reset_i || wdt_timeout_i;
  assign wake_any   = irq_valid_i && ((state != ST_SLEEP) || irq_runs_in_sleep_i);
  assign wake_cpu   = wake_any && (irq_prio_i > cpu_prio_i);
  assign need_delay = new_src_stopped_i && (new_src_xtal_i || new_src_pll_i);
  assign delay_load = DELAY_W'((new_src_xtal_i ? OSC_START_CYCLES : 0)
                    + (new_src_pll_i ? PLL_LOCK_CYCLES : 0));

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RUN:
        if (clk_switch_i && need_delay)
          next_state = ST_START;
        else if (wait_exec_i)
          next_state = sleep_sel ? ST_SLEEP : ST_IDLE;
      ST_IDLE:
        if (abort_lp || wake_cpu)
          next_state = ST_RUN;
      ST_SLEEP:
        if (abort_lp || wake_cpu)
          next_state = ST_RUN;
        else if (wake_any)
          next_state = ST_IDLE;
      ST_START:
        if (delay_cnt <= 16'h0001)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      delay_cnt <= 16'h0000;
    else if (state == ST_RUN && next_state == ST_START)
      delay_cnt <= delay_load;
    else if (delay_cnt != 16'h0000)
      delay_cnt <= delay_cnt - 16'h0001;
  end

  // sleep stops the divided bus; idle and start-up keep it running
  assign bus_run          = (state != ST_SLEEP);
  assign cpu_run_o        = (state == ST_RUN);
  assign sys_clk_en_o     = (state != ST_SLEEP);
  assign system_core_clock_unit_en_o = (state != ST_SLEEP);
  assign src_ready_o      = (state != ST_START);
  assign pwr_mode_o       = (state == ST_SLEEP) ? 2'h2 : (state == ST_IDLE) ? 2'h1 : 2'h0;

  periph_clk_div u_div
  (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .run_i        (bus_run),
    .divisor_i    (div_sel),
    .tick_o       (tick),
    .active_div_o (active_div_o)
  );

  assign periph_bus_clock_o = tick;
  assign periph_clk_en_o    = {PERIPH_N{tick}} &
                              ~({PERIPH_N{state == ST_IDLE}} & stop_in_idle_i);

  // read waits for the next bus tick; 1:1 completes in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_pending <= 1'b0;
    else if (tick)
      rd_pending <= 1'b0;
    else if (periph_rd_req_i)
      rd_pending <= 1'b1;
  end

  assign periph_rd_done_o = tick && (rd_pending || periph_rd_req_i);

  a_abort_wakes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((state == ST_IDLE || state == ST_SLEEP) && abort_lp) |=> (state == ST_RUN))
    else $error("reset or watchdog did not end low power");
  a_wait_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_RUN && wait_exec_i && !clk_switch_i)
      |=> (state == ($past(sleep_sel) ? ST_SLEEP : ST_IDLE)))
    else $error("wait entered wrong mode");
  a_sleep_low_prio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_SLEEP && wake_any && !wake_cpu && !abort_lp)
      |=> (state == ST_IDLE && !cpu_run_o))
    else $error("low priority sleep wake not idle");
  a_sleep_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_SLEEP && wake_cpu) |=> cpu_run_o)
    else $error("sleep wake failed");
  a_idle_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_IDLE && !wake_cpu && !abort_lp) |=> (state == ST_IDLE))
    else $error("idle left without qualified wake");
  a_idle_clock: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_IDLE) |-> (sys_clk_en_o && !cpu_run_o))
    else $error("idle clock state wrong");
  a_stop_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_IDLE) |-> ((periph_clk_en_o & stop_in_idle_i) == '0))
    else $error("stopped peripheral clocked in idle");
  a_rd_latency: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (periph_rd_req_i && !tick && active_div_o == DIV_8 && state == ST_RUN)
      |-> ##[1:7] periph_rd_done_o)
    else $error("peripheral read latency exceeded");
  a_startup_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state == ST_RUN && clk_switch_i && need_delay) |=> !src_ready_o)
    else $error("no startup delay inserted");
endmodule : pwr_ctl
`default_nettype wire

// ### hdl/pwr_ctl_pkg.sv
// constants and types shared by the power-saving controller
package pwr_ctl_pkg;
  localparam int          PRIO_W          = 3;
  localparam int          DIV_W           = 2;
  localparam int          PERIPH_N        = 8;
  localparam int          SLEEP_SEL_BIT   = 4;
  localparam int          DIV_LSB_BIT     = 19;
  localparam int          DIV_MSB_BIT     = 20;
  localparam int          OSC_CTL_W       = 32;
  localparam logic [1:0]  DIV_1           = 2'h0;
  localparam logic [1:0]  DIV_2           = 2'h1;
  localparam logic [1:0]  DIV_4           = 2'h2;
  localparam logic [1:0]  DIV_8           = 2'h3;
  localparam logic [1:0]  DIV_RESET       = 2'h0;
  localparam int          CNT_W           = 3;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          OSC_START_NS    = 10000;
  localparam int          PLL_LOCK_NS     = 20000;
  localparam int          OSC_START_CYC   = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PLL_LOCK_CYC    = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DELAY_W         = 16;

  typedef enum logic [3:0]
  {
    ST_RUN   = 4'h1,
    ST_IDLE  = 4'h2,
    ST_SLEEP = 4'h4,
    ST_START = 4'h8
  } pwr_state_t;
endpackage : pwr_ctl_pkg

// ### hdl/periph_clk_div.sv
// peripheral bus clock enable divider, ratio change only at a period boundary
`timescale 1ns/10ps
`default_nettype none
module periph_clk_div
  import pwr_ctl_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  tick_o,
  output logic [DIV_W-1:0]      active_div_o
);
  logic [CNT_W-1:0] cnt;
  logic [DIV_W-1:0] cur_div;
  wire  [CNT_W-1:0] last_cnt;
  wire              at_end;

  function automatic logic [CNT_W-1:0] last_of(input logic [DIV_W-1:0] d);
    unique case (d)
      DIV_1:   last_of = 3'h0;
      DIV_2:   last_of = 3'h1;
      DIV_4:   last_of = 3'h3;
      default: last_of = 3'h7;
    endcase
  endfunction : last_of

  assign last_cnt     = last_of(cur_div);
  assign at_end       = (cnt == last_cnt);
  assign tick_o       = run_i && at_end;
  assign active_div_o = cur_div;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt     <= 3'h0;
      cur_div <= DIV_RESET;
    end
    else if (run_i)
    begin
      cnt <= at_end ? 3'h0 : cnt + 3'h1;
      if (at_end)
        cur_div <= divisor_i;
    end
  end

  a_div_boundary: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cur_div != $past(cur_div)) |-> ($past(cnt) == last_of($past(cur_div))))
    else $error("divisor changed inside a period");
  a_tick_period: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tick_o && cur_div == DIV_8 && divisor_i == DIV_8 && $stable(cur_div))
      |=> !tick_o [*7])
    else $error("1:8 tick spacing wrong");
endmodule : periph_clk_div
`default_nettype wire

// ### verif/periph_tick_model.sv
// peripheral-side model: counts divided bus clock ticks
`timescale 1ns/10ps
`default_nettype none
module periph_tick_model
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       clr_i,
  output logic      [7:0] tick_cnt_o
);
  // peripherals only advance on a divided tick
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      tick_cnt_o <= 8'h00;
    else if (clr_i)
      tick_cnt_o <= 8'h00;
    else if (tick_i)
      tick_cnt_o <= tick_cnt_o + 8'h01;
endmodule : periph_tick_model
`default_nettype wire

// ### verif/sleep_idle_and_periph_clock_divider_bench.sv
// bench for the power-saving controller
`timescale 1ns/10ps
`default_nettype none
module sleep_idle_and_periph_clock_divider_bench
  import pwr_ctl_pkg::*;
;
  localparam int OSC_C = 5;
  localparam int PLL_C = 7;
  logic clk = 1'b0, rst_n = 1'b0, wt = 1'b0, wdt = 1'b0, drst = 1'b0;
  logic iv = 1'b0, irs = 1'b0, csw = 1'b0, nst = 1'b0, nx = 1'b0;
  logic npl = 1'b0, rdq = 1'b0, clr = 1'b0;
  logic [31:0] ctl = 32'h0;
  logic [2:0] ip = 3'h0, cp = 3'h0;
  logic [7:0] sid = 8'h00, pen, tcnt;
  logic cpu_run, sclk_en, unit_en, periph_bus_clock, rdone, srdy;
  logic [1:0] mode, adiv;
  int err_total = 0, comparisons = 0, n;

  always #5 clk = ~clk;

  pwr_ctl #(.OSC_START_CYCLES(OSC_C), .PLL_LOCK_CYCLES(PLL_C)) uut (
    .core_clk_i(clk), .rst_n_i(rst_n), .oscillator_control_reg_i(ctl),
    .wait_exec_i(wt), .wdt_timeout_i(wdt), .dev_reset_i(drst),
    .irq_valid_i(iv), .irq_runs_in_sleep_i(irs), .irq_prio_i(ip),
    .cpu_prio_i(cp), .stop_in_idle_i(sid), .clk_switch_i(csw),
    .new_src_stopped_i(nst), .new_src_xtal_i(nx), .new_src_pll_i(npl),
    .periph_rd_req_i(rdq), .cpu_run_o(cpu_run), .sys_clk_en_o(sclk_en),
    .system_core_clock_unit_en_o(unit_en), .periph_bus_clock_o(periph_bus_clock),
    .periph_clk_en_o(pen), .periph_rd_done_o(rdone),
    .src_ready_o(srdy), .pwr_mode_o(mode), .active_div_o(adiv));

  periph_tick_model part (.core_clk_i(clk), .rst_n_i(rst_n),
    .tick_i(periph_bus_clock), .clr_i(clr), .tick_cnt_o(tcnt));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // a wait that ran out of bound ends the run
  task automatic bound(input int lim);
    if (n >= lim)
    begin
      err_total++;
      complete_run();
    end
  endtask : bound

  task automatic go_wait(input logic slp);
    ctl[SLEEP_SEL_BIT] = slp;
    wt = 1'b1;
    cyc(1);
    wt = 1'b0;
  endtask : go_wait

  task automatic t_sleep;
    go_wait(1'b1);
    chk("mode", 32'h2, mode);
    chk("sys_clk_en", 32'h0, sclk_en);
    chk("bus_clock", 32'h0, periph_bus_clock);
    ip = 3'h5; cp = 3'h2; irs = 1'b0; iv = 1'b1;
    cyc(1);
    chk("mode", 32'h2, mode);
    irs = 1'b1;
    cyc(1);
    chk("cpu_run", 32'h1, cpu_run);
    iv = 1'b0;
    cyc(1);
    $display("test sleep wake done");
  endtask : t_sleep

  task automatic t_idle;
    go_wait(1'b1);
    ip = 3'h2; sid = 8'hA5; iv = 1'b1;
    cyc(1);
    chk("mode", 32'h1, mode);
    cyc(2);
    chk("cpu_run", 32'h0, cpu_run);
    n = 0;
    while (periph_bus_clock !== 1'b1 && n < 16) begin cyc(1); n++; end
    bound(16);
    chk("periph_en", 32'h5A, pen);
    chk("sys_clk_en", 32'h1, sclk_en);
    chk("unit_en", 32'h1, unit_en);
    ip = 3'h3;
    cyc(1);
    chk("cpu_run", 32'h1, cpu_run);
    chk("periph_en", 32'hFF, pen);
    iv = 1'b0;
    go_wait(1'b0);
    chk("mode", 32'h1, mode);
    wdt = 1'b1;
    cyc(1);
    wdt = 1'b0;
    chk("mode", 32'h0, mode);
    go_wait(1'b1);
    drst = 1'b1;
    cyc(1);
    drst = 1'b0;
    chk("mode", 32'h0, mode);
    $display("test idle done");
  endtask : t_idle

  task automatic t_div;
    for (int d = 0; d < 4; d++)
    begin
      ctl[DIV_MSB_BIT:DIV_LSB_BIT] = 2'(d);
      n = 0;
      while (adiv !== 2'(d) && n < 16) begin cyc(1); n++; end
      bound(16);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(64);
      chk("ticks", 32'(64 >> d), tcnt);
    end
    n = 0;
    while (periph_bus_clock !== 1'b1 && n < 16) begin cyc(1); n++; end
    bound(16);
    cyc(1);
    chk("bus_clock", 32'h0, periph_bus_clock);
    chk("unit_en", 32'h1, unit_en);
    rdq = 1'b1;
    cyc(1);
    rdq = 1'b0;
    n = 1;
    while (rdone !== 1'b1 && n < 16) begin cyc(1); n++; end
    chk("rd_latency", 32'h7, n);
    ctl = 32'h0;
    $display("test divider done");
  endtask : t_div

  task automatic t_switch;
    csw = 1'b1; nst = 1'b1; nx = 1'b1; npl = 1'b1;
    cyc(1);
    csw = 1'b0;
    n = 0;
    while (srdy !== 1'b1 && n < 100) begin cyc(1); n++; end
    bound(100);
    chk("start_delay", 32'h1, n >= OSC_C + PLL_C && n <= OSC_C + PLL_C + 1);
    nst = 1'b0; csw = 1'b1;
    cyc(1);
    csw = 1'b0;
    chk("src_ready", 32'h1, srdy);
    $display("test clock switch done");
  endtask : t_switch

  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(1);
    t_sleep();
    t_idle();
    t_div();
    t_switch();
    complete_run();
  end
endmodule : sleep_idle_and_periph_clock_divider_bench
`default_nettype wire
